// ==== core/rbrm_regs.svh ====
`ifndef RBRM_REGS_SVH
`define RBRM_REGS_SVH

// Register offsets
`define RBRM_A_CMD 4'h0
`define RBRM_A_FIRST 4'h1
`define RBRM_A_END 4'h2
`define RBRM_A_BND 4'h3
`define RBRM_A_ISR 4'h4
`define RBRM_A_WPP 4'h5
`define RBRM_A_RCL 4'h6
`define RBRM_A_RCH 4'h7
`define RBRM_A_TCR 4'h8
`define RBRM_A_RCR 4'h9
`define RBRM_A_DMA 4'ha

// Command bits
`define RBRM_CMD_HALT 0
`define RBRM_CMD_START 1
`define RBRM_CMD_RST 8'h21

// Interrupt status bits
`define RBRM_ISR_PRX 0
`define RBRM_ISR_RXE 2
`define RBRM_ISR_OVW 4
`define RBRM_ISR_RST 7
`define RBRM_ISR_RSTV 8'h80

// Transmit configuration loopback field
`define RBRM_TCR_LB_HI 2
`define RBRM_TCR_LB_LO 1
`define RBRM_LB_OFF 2'h0
`define RBRM_LB_MODE1 2'h1

// Receive configuration accept bits
`define RBRM_RCR_ERR 0
`define RBRM_RCR_RUNT 1

// Receive status byte bits
`define RBRM_STAT_OK 0
`define RBRM_STAT_CRC 1
`define RBRM_STAT_FAE 2

// Header room at packet start, last byte of a page
`define RBRM_HDR_OFF 8'h04
`define RBRM_PAGE_LAST 8'hff

// Timing
`define RBRM_CLK_NS 8
`define RBRM_LONG_PKT_MS 1.2
`define RBRM_LB1_STOP_US 2
`define RBRM_LONG_PKT_CYC ($rtoi(`RBRM_LONG_PKT_MS * 1.0e6 / `RBRM_CLK_NS))
`define RBRM_LB1_STOP_CYC (`RBRM_LB1_STOP_US * 1000 / `RBRM_CLK_NS)

`endif

// ==== core/rbrm_pkg.sv ====
package rbrm_pkg;

	// Receive controller states
	typedef enum logic [1:0] {ST_IDLE, ST_STORE, ST_SKIP, ST_HEADER} rbrm_state_t;

	// End-of-frame verdict from the receiver
	typedef struct packed {
		logic runt;
		logic crc_err;
		logic align_err;
	} rbrm_rxend_t;

	// One write to local buffer memory
	typedef struct packed {
		logic we;
		logic [15:0] addr;
		logic [7:0] data;
	} rbrm_mem_wr_t;

endpackage

// ==== core/rbrm_page_step.sv ====
// Next ring page after a given page, with wrap and boundary test
module rbrm_page_step
	import rbrm_pkg::*;
(
	input wire logic [7:0] CUR_PAGE,
	input wire logic [7:0] FIRST_PAGE,
	input wire logic [7:0] END_PAGE,
	input wire logic [7:0] BND_PAGE,
	output logic [7:0] NEXT_PAGE,
	output logic NEXT_IS_BND
);

	// Plain successor page
	wire [7:0] plus_one = CUR_PAGE + 8'h01;

	// Successor equal to end page becomes the first page
	assign NEXT_PAGE = (plus_one == END_PAGE) ? FIRST_PAGE : plus_one;

	// Successor after wrap lands on unread data
	assign NEXT_IS_BND = (NEXT_PAGE == BND_PAGE);

endmodule // rbrm_page_step

// ==== core/rbrm_top.sv ====
// The placing of the registers and the address-and-strobe port were decided locally.
`include "rbrm_regs.svh"

module rbrm_top
	import rbrm_pkg::*;
#(
	parameter int unsigned STOP_LONG_CYC = `RBRM_LONG_PKT_CYC
)
(
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic [3:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	input wire logic RX_START,
	input wire logic RX_VALID,
	input wire logic [7:0] RX_DATA,
	output logic RX_READY,
	input wire logic RX_END,
	input wire rbrm_rxend_t RX_STAT,
	input wire logic TX_BUSY,
	output rbrm_mem_wr_t MEM_WR,
	input wire logic REMOTE_DONE,
	input wire logic [7:0] REMOTE_NEXT_PAGE,
	output logic [7:0] REMOTE_START_PAGE,
	output logic STOPPED
);

	// Address match for one register
	function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
		hit = (a == off);
	endfunction

	// Software registers
	logic [7:0] cmd_r; // Last command written
	logic [7:0] first_r; // Ring first page
	logic [7:0] end_r; // Ring end page
	logic [7:0] bnd_r; // Boundary (read) page
	logic [7:0] isr_r; // Sticky status
	logic [7:0] wpp_r; // Write page pointer
	logic [7:0] rcl_r; // Remote count low
	logic [7:0] rch_r; // Remote count high
	logic [7:0] tcr_r; // Transmit configuration
	logic [7:0] rcr_r; // Receive configuration
	logic [7:0] rdata_r; // Read data stage

	// Receive machine
	rbrm_state_t state_r;
	rbrm_state_t state_nxt;
	logic [7:0] dma_page_r; // Page being filled
	logic [7:0] dma_off_r; // Byte offset in page
	logic abort_r; // Packet hit the boundary
	logic [15:0] cnt_r; // Received byte count
	logic [7:0] next_pkt_r; // Scratchpad next packet page
	logic [7:0] stat_r; // Status byte for header
	logic [1:0] hdr_idx_r; // Header byte index
	rbrm_mem_wr_t mem_r; // Memory write stage

	// Halt control
	logic halt_req_r; // Halt requested since the last start, stays set once stopped
	logic stopped_r; // Receive side stopped
	logic rst_done_r; // Reset flag already raised for this halt
	logic [17:0] stop_cnt_r; // Cycles since halt request

	// Register writes
	wire wr_cmd = WR && hit(ADDR, `RBRM_A_CMD);
	wire wr_isr = WR && hit(ADDR, `RBRM_A_ISR);
	wire halt_wr = wr_cmd && WDATA[`RBRM_CMD_HALT];
	wire start_wr = wr_cmd && WDATA[`RBRM_CMD_START] && !WDATA[`RBRM_CMD_HALT];

	// Mode decode
	wire [1:0] lb_mode = tcr_r[`RBRM_TCR_LB_HI:`RBRM_TCR_LB_LO];
	wire loopback = (lb_mode != `RBRM_LB_OFF);
	wire counts_zero = (rcl_r == 8'h00) && (rch_r == 8'h00);
	wire rx_on = cmd_r[`RBRM_CMD_START] && !halt_req_r && !stopped_r && !loopback;

	// Stream handshake and events
	assign RX_READY = ((state_r == ST_STORE) || (state_r == ST_SKIP)) && !RX_END;
	wire byte_take = RX_VALID && RX_READY;
	wire start_take = (state_r == ST_IDLE) && RX_START && rx_on;
	wire skip_take = (state_r == ST_IDLE) && RX_START && !rx_on;
	wire store_byte = (state_r == ST_STORE) && byte_take && !abort_r;
	wire link_now = store_byte && (dma_off_r == `RBRM_PAGE_LAST);
	wire end_seen = (state_r == ST_STORE) && RX_END;
	wire hdr_last = (state_r == ST_HEADER) && (hdr_idx_r == 2'h3);

	// Page successor for linking
	logic [7:0] next_page;
	logic next_is_bnd;
	rbrm_page_step u_step (
		.CUR_PAGE(dma_page_r),
		.FIRST_PAGE(first_r),
		.END_PAGE(end_r),
		.BND_PAGE(bnd_r),
		.NEXT_PAGE(next_page),
		.NEXT_IS_BND(next_is_bnd)
	);
	wire link_block = link_now && next_is_bnd;

	// Rejection unless the matching accept bit is set
	wire bad_runt = RX_STAT.runt && !rcr_r[`RBRM_RCR_RUNT];
	wire bad_err = (RX_STAT.crc_err || RX_STAT.align_err) && !rcr_r[`RBRM_RCR_ERR];
	wire reject = end_seen && !abort_r && (bad_runt || bad_err);
	wire accept = end_seen && !abort_r && !bad_runt && !bad_err;
	// Unused tail of last page is dropped; an untouched page is reused
	wire [7:0] pkt_next = (dma_off_r == 8'h00) ? dma_page_r : next_page;

	// Halt timing: short in loopback mode 1, else one longest packet
	wire [17:0] stop_lim = (lb_mode == `RBRM_LB_MODE1) ?
		18'(`RBRM_LB1_STOP_CYC) : 18'(STOP_LONG_CYC);
	wire stop_due = halt_req_r && (stop_cnt_r >= stop_lim);
	wire stop_ok = halt_req_r && (state_r == ST_IDLE) && !TX_BUSY;
	wire rst_set = stop_ok && counts_zero && !rst_done_r;

	// Status byte for an accepted packet: intact only without check or framing error
	wire rx_clean = !RX_STAT.crc_err && !RX_STAT.align_err;
	wire [7:0] stat_byte = ({7'h00, rx_clean} << `RBRM_STAT_OK)
		| {7'h00, RX_STAT.crc_err} << `RBRM_STAT_CRC
		| {7'h00, RX_STAT.align_err} << `RBRM_STAT_FAE;

	// Header byte order
	wire [7:0] hdr_byte = (hdr_idx_r == 2'h0) ? stat_r :
		(hdr_idx_r == 2'h1) ? next_pkt_r :
		(hdr_idx_r == 2'h2) ? cnt_r[7:0] : cnt_r[15:8];

	// Sticky status: hardware set wins over software clear
	wire [7:0] isr_set = ({7'h00, hdr_last} << `RBRM_ISR_PRX)
		| ({7'h00, reject} << `RBRM_ISR_RXE)
		| ({7'h00, link_block} << `RBRM_ISR_OVW)
		| ({7'h00, rst_set} << `RBRM_ISR_RST);
	wire [7:0] isr_clr = wr_isr ? WDATA : 8'h00;
	wire [7:0] isr_nxt = (isr_r & ~isr_clr) | isr_set;

	// Read selection
	wire [7:0] rd_mux = hit(ADDR, `RBRM_A_CMD) ? cmd_r :
		hit(ADDR, `RBRM_A_FIRST) ? first_r :
		hit(ADDR, `RBRM_A_END) ? end_r :
		hit(ADDR, `RBRM_A_BND) ? bnd_r :
		hit(ADDR, `RBRM_A_ISR) ? isr_r :
		hit(ADDR, `RBRM_A_WPP) ? wpp_r :
		hit(ADDR, `RBRM_A_RCL) ? rcl_r :
		hit(ADDR, `RBRM_A_RCH) ? rch_r :
		hit(ADDR, `RBRM_A_TCR) ? tcr_r :
		hit(ADDR, `RBRM_A_RCR) ? rcr_r :
		hit(ADDR, `RBRM_A_DMA) ? dma_page_r : 8'h00;

	// Next state of the receive machine
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE:
			begin
				// Enabled packets are stored, others are drained
				if (start_take)
					state_nxt = ST_STORE;
				else if (skip_take)
					state_nxt = ST_SKIP;
			end
			ST_STORE:
			begin
				// A halt that times out cuts the packet short
				if (stop_due)
					state_nxt = ST_IDLE;
				else if (accept)
					state_nxt = ST_HEADER;
				else if (RX_END)
					state_nxt = ST_IDLE;
			end
			ST_SKIP:
			begin
				// Drop bytes until frame end
				if (RX_END)
					state_nxt = ST_IDLE;
			end
			ST_HEADER:
			begin
				// Four header bytes, then done
				if (hdr_idx_r == 2'h3)
					state_nxt = ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
			state_r <= ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// DMA page: start, link, rewind on reject
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
			dma_page_r <= 8'h00;
		else if (start_take)
			dma_page_r <= wpp_r;
		else if (link_now && !next_is_bnd)
			dma_page_r <= next_page;
		else if (reject)
			dma_page_r <= wpp_r;
	end

	// Offset in page, header room first
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
			dma_off_r <= 8'h00;
		else if (start_take)
			dma_off_r <= `RBRM_HDR_OFF;
		else if (store_byte)
			dma_off_r <= dma_off_r + 8'h01;
	end

	// Overflow abort and byte count
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			abort_r <= 1'b0;
			cnt_r <= 16'h0000;
		end
		else if (start_take)
		begin
			abort_r <= 1'b0;
			cnt_r <= 16'h0000;
		end
		else
		begin
			abort_r <= abort_r | link_block;
			cnt_r <= cnt_r + {15'h0000, store_byte};
		end
	end

	// Scratchpad for header and next write page
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			next_pkt_r <= 8'h00;
			stat_r <= 8'h00;
		end
		else if (accept)
		begin
			next_pkt_r <= pkt_next;
			stat_r <= stat_byte;
		end
	end

	// Header byte index
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
			hdr_idx_r <= 2'h0;
		else if (state_r == ST_HEADER)
			hdr_idx_r <= hdr_idx_r + 2'h1;
		else
			hdr_idx_r <= 2'h0;
	end

	// Memory writes: each data byte up to a boundary abort, including check sequence, then header after an accepted packet
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
			mem_r <= '0;
		else if (store_byte)
			mem_r <= '{we: 1'b1, addr: {dma_page_r, dma_off_r}, data: RX_DATA};
		else if (state_r == ST_HEADER)
			mem_r <= '{we: 1'b1, addr: {wpp_r, 6'h00, hdr_idx_r}, data: hdr_byte};
		else
			mem_r <= '0;
	end

	// Halt request, stopped state and its flag guard
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			halt_req_r <= 1'b0;
			stopped_r <= 1'b1;
			rst_done_r <= 1'b1;
		end
		else if (start_wr)
		begin
			halt_req_r <= 1'b0;
			stopped_r <= 1'b0;
			rst_done_r <= 1'b0;
		end
		else
		begin
			halt_req_r <= halt_req_r | halt_wr;
			stopped_r <= stopped_r | stop_ok | stop_due;
			rst_done_r <= rst_done_r | rst_set;
		end
	end

	// Halt timer
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
			stop_cnt_r <= 18'h00000;
		else if (!halt_req_r || stopped_r)
			stop_cnt_r <= 18'h00000;
		else if (!stop_due)
			stop_cnt_r <= stop_cnt_r + 18'h00001;
	end

	// Write page: hardware update wins over software
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
			wpp_r <= 8'h00;
		else if (hdr_last)
			wpp_r <= next_pkt_r;
		else if (WR && hit(ADDR, `RBRM_A_WPP))
			wpp_r <= WDATA;
	end

	// Boundary: remote removal advances it
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
			bnd_r <= 8'h00;
		else if (REMOTE_DONE)
			bnd_r <= REMOTE_NEXT_PAGE;
		else if (WR && hit(ADDR, `RBRM_A_BND))
			bnd_r <= WDATA;
	end

	// Plain software registers and status
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			cmd_r <= `RBRM_CMD_RST;
			first_r <= 8'h00;
			end_r <= 8'h00;
			rcl_r <= 8'h00;
			rch_r <= 8'h00;
			tcr_r <= 8'h00;
			rcr_r <= 8'h00;
			isr_r <= `RBRM_ISR_RSTV;
		end
		else
		begin
			cmd_r <= wr_cmd ? WDATA : cmd_r;
			first_r <= (WR && hit(ADDR, `RBRM_A_FIRST)) ? WDATA : first_r;
			end_r <= (WR && hit(ADDR, `RBRM_A_END)) ? WDATA : end_r;
			rcl_r <= (WR && hit(ADDR, `RBRM_A_RCL)) ? WDATA : rcl_r;
			rch_r <= (WR && hit(ADDR, `RBRM_A_RCH)) ? WDATA : rch_r;
			tcr_r <= (WR && hit(ADDR, `RBRM_A_TCR)) ? WDATA : tcr_r;
			rcr_r <= (WR && hit(ADDR, `RBRM_A_RCR)) ? WDATA : rcr_r;
			isr_r <= isr_nxt;
		end
	end

	// Read data, one cycle after the strobe
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
			rdata_r <= 8'h00;
		else
			rdata_r <= RD ? rd_mux : 8'h00;
	end

	assign RDATA = rdata_r;
	assign MEM_WR = mem_r;
	assign REMOTE_START_PAGE = bnd_r;
	assign STOPPED = stopped_r;

	// Checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);

	// Header bytes go out in order at the packet's first page
	sequence s_hdr(logic [7:0] pg);
		mem_r.we && mem_r.addr == {pg, 8'h00} ##1 mem_r.addr == {pg, 8'h01}
		##1 mem_r.addr == {pg, 8'h02} ##1 mem_r.addr == {pg, 8'h03};
	endsequence

	a_never_end_page: assert property (state_r == ST_STORE && end_r != first_r
		&& $stable(end_r) |-> dma_page_r != end_r || $past(state_r) == ST_IDLE)
		else $error("DMA page sits on ring end page");
	a_start_offset: assert property (start_take |=> dma_off_r == 8'h04
		&& dma_page_r == $past(wpp_r))
		else $error("Packet did not start at write page plus four");
	a_link_contig: assert property (link_now && !next_is_bnd |=>
		dma_page_r == $past(next_page) && dma_off_r == 8'h00)
		else $error("Page link did not go to next page");
	a_link_wrap: assert property (link_now && dma_page_r + 8'h01 == end_r
		&& !next_is_bnd |=> dma_page_r == first_r)
		else $error("Link at end page did not wrap to first");
	a_bnd_abort: assert property (link_block |=> abort_r && isr_r[`RBRM_ISR_OVW]
		##1 !mem_r.we [*2])
		else $error("Boundary hit did not abort and flag");
	a_rst_counts: assert property ($rose(isr_r[`RBRM_ISR_RST]) |->
		$past(counts_zero) && $past(state_r) == ST_IDLE)
		else $error("Reset flag set with counts nonzero or packet busy");
	a_stop_bound: assert property (halt_req_r && !stopped_r && stop_cnt_r == stop_lim
		|=> stopped_r)
		else $error("Halt not reached in time");
	a_loop_quiet: assert property (loopback && state_r == ST_IDLE |=>
		state_r != ST_STORE)
		else $error("Receive DMA started in loopback");
	a_hdr_write: assert property (accept |=> ##1 s_hdr($past(wpp_r)))
		else $error("Header not written at packet's first page");
	a_write_page_pointer_load: assert property (hdr_last |=> wpp_r == $past(next_pkt_r)
		&& state_r == ST_IDLE)
		else $error("Write page not loaded from scratchpad");
	a_reject_rewind: assert property (reject |=> dma_page_r == $past(wpp_r)
		&& state_r == ST_IDLE && !mem_r.we)
		else $error("Rejected packet did not rewind");

endmodule // rbrm_top

// ==== test/rbrm_mem_model.sv ====
// Local buffer memory: keeps every byte the receive DMA writes
module rbrm_mem_model
	import rbrm_pkg::*;
(
	input wire logic CLK,
	input wire rbrm_mem_wr_t MEM_WR
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:65535]; // Byte store
	int wr_cnt = 0; // Writes seen so far
	// One byte per cycle while the strobe is high
	always @(posedge CLK)
	begin
		if (MEM_WR.we === 1'b1)
		begin
			mem[MEM_WR.addr] <= MEM_WR.data;
			wr_cnt <= wr_cnt + 1;
		end
	end
endmodule // rbrm_mem_model

// ==== test/rbrm_top_test.sv ====
`include "rbrm_regs.svh"

module rbrm_top_test
	import rbrm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LONG_CYC = 300; // Shortened long packet time
	localparam int LB1_CYC = `RBRM_LB1_STOP_CYC; // Loopback mode 1 stop time
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic [7:0] rdata;
	logic rx_start = 1'b0;
	logic rx_valid = 1'b0;
	logic [7:0] rx_data = 8'h00;
	logic rx_ready;
	logic rx_end = 1'b0;
	rbrm_rxend_t rx_stat = '0;
	logic tx_busy = 1'b0;
	rbrm_mem_wr_t mem_wr;
	logic remote_done = 1'b0;
	logic [7:0] remote_next_page = 8'h00;
	logic [7:0] remote_start_page;
	logic stopped;
	int err_count = 0;
	int checks = 0;
	int first_pg, end_pg, bnd_pg, wp; // Ring model
	int wrote; // Bytes written by the last frame

	always #4 clk = ~clk;

	rbrm_top #(.STOP_LONG_CYC(LONG_CYC)) uut (.CLK(clk), .RST_B(rst_b), .ADDR(addr),
		.WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata), .RX_START(rx_start),
		.RX_VALID(rx_valid), .RX_DATA(rx_data), .RX_READY(rx_ready), .RX_END(rx_end),
		.RX_STAT(rx_stat), .TX_BUSY(tx_busy), .MEM_WR(mem_wr), .REMOTE_DONE(remote_done),
		.REMOTE_NEXT_PAGE(remote_next_page), .REMOTE_START_PAGE(remote_start_page),
		.STOPPED(stopped));

	rbrm_mem_model bufm (.CLK(clk), .MEM_WR(mem_wr));

	// Value comparison
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Register write, one gap cycle after it
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask

	// Register read; data stands in the following cycle only
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(negedge clk);
		v = rdata;
	endtask

	// Next ring page with wrap at the end page
	function automatic int nxt(input int p);
		return (p + 1 == end_pg) ? first_pg : p + 1;
	endfunction

	// Feeds one frame; for accepted frames checks data and header
	task automatic send(input int n, input rbrm_rxend_t st, input bit acc);
		logic [7:0] q[$];
		logic [7:0] v;
		logic ok;
		int w0;
		int pg;
		int off;
		w0 = bufm.wr_cnt;
		pg = wp;
		off = 4;
		@(posedge clk);
		rx_start <= 1'b1;
		@(posedge clk);
		rx_start <= 1'b0;
		for (int i = 0; i < n; i++)
		begin
			q.push_back(8'($urandom));
			rx_valid <= 1'b1;
			rx_data <= q[i];
			ok = 1'b0;
			// Byte is taken at the edge after ready was seen high
			for (int t = 0; t < 20 && !ok; t++)
			begin
				@(negedge clk);
				ok = (rx_ready === 1'b1);
				@(posedge clk);
			end
		end
		rx_valid <= 1'b0;
		rx_end <= 1'b1;
		rx_stat <= st;
		@(posedge clk);
		rx_end <= 1'b0;
		repeat (6) @(posedge clk);
		wrote = bufm.wr_cnt - w0;
		if (acc)
		begin
			// Data and check sequence stored back to back across pages
			for (int i = 0; i < n; i++)
			begin
				chk("stored byte", q[i], bufm.mem[{pg[7:0], off[7:0]}]);
				off++;
				if (off == 256)
				begin
					pg = nxt(pg);
					off = 0;
				end
			end
			if (off != 0)
				pg = nxt(pg);
			if (!st.runt)
				chk("status", {st.align_err, st.crc_err, !(st.crc_err | st.align_err)},
					bufm.mem[{wp[7:0], 8'h00}]);
			chk("next page", pg[7:0], bufm.mem[{wp[7:0], 8'h01}]);
			chk("count low", n[7:0], bufm.mem[{wp[7:0], 8'h02}]);
			chk("count high", n[15:8], bufm.mem[{wp[7:0], 8'h03}]);
			chk("accept writes", 16'(n + 4), 16'(wrote));
			rd(`RBRM_A_WPP, v);
			chk("write page", pg[7:0], v);
			wp = pg;
		end
	endtask

	// Remote removal done: boundary takes the new page
	task automatic remote(input int p);
		logic [7:0] v;
		@(posedge clk);
		remote_done <= 1'b1;
		remote_next_page <= p[7:0];
		@(posedge clk);
		remote_done <= 1'b0;
		remote_next_page <= ~p[7:0];
		rd(`RBRM_A_BND, v);
		chk("boundary", p[7:0], v);
		chk("remote start", p[7:0], remote_start_page);
		bnd_pg = p;
	endtask

	// Cycles until the receive side reports stopped
	task automatic wait_stop(output int c);
		c = 0;
		while (stopped !== 1'b1 && c < 1000)
		begin
			@(negedge clk);
			c++;
		end
	endtask

	// Count line, verdict and end of run
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Hang guard
	initial
	begin
		#400000;
		err_count++;
		$display("ERROR watchdog expected done seen timeout");
		summarize();
	end

	// Main sequence
	initial
	begin
		logic [7:0] v;
		int c;
		rbrm_rxend_t st;
		void'($urandom(32'h95fb));
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		for (int a = 0; a < 16; a++)
		begin
			rd(4'(a), v);
			chk("reset reg", (a == 0) ? 8'h21 : ((a == 4) ? 8'h80 : 8'h00), v);
		end
		wr(4'hc, 8'h55);
		rd(4'hc, v);
		chk("unmapped reg", 8'h00, v);
		chk("stopped at reset", 16'h0001, 16'(stopped));
		$display("test reset: done");
		// Ring set up by software
		first_pg = 8'h40;
		end_pg = 8'h46;
		wp = 8'h40;
		wr(`RBRM_A_FIRST, 8'h40);
		wr(`RBRM_A_END, 8'h46);
		wr(`RBRM_A_BND, 8'h40);
		wr(`RBRM_A_WPP, 8'h40);
		wr(`RBRM_A_ISR, 8'hff);
		wr(`RBRM_A_CMD, 8'h22);
		send(252, 3'b000, 1);
		send(253 + $urandom % 47, 3'b000, 1);
		remote(wp);
		send(800, 3'b000, 1);
		remote(wp + 4);
		$display("test ring: done");
		// Rejected and kept error frames
		for (int k = 0; k < 6; k++)
		begin
			st = rbrm_rxend_t'(3'b100 >> (k % 3));
			wr(`RBRM_A_RCR, (k < 3) ? 8'h00 : 8'h03);
			wr(`RBRM_A_ISR, 8'hff);
			send((k < 3) ? 300 : 80, st, k >= 3);
			if (k < 3)
			begin
				chk("reject writes", 16'd300, 16'(wrote));
				rd(`RBRM_A_DMA, v);
				chk("dma rewind", wp[7:0], v);
				rd(`RBRM_A_ISR, v);
				chk("reject flag", 16'h0001, 16'(v[2]));
			end
		end
		$display("test errors: done");
		// Link into the boundary page
		wr(`RBRM_A_ISR, 8'hff);
		send(300, 3'b000, 0);
		chk("abort writes", 16'd252, 16'(wrote));
		rd(`RBRM_A_ISR, v);
		chk("overwrite flag", 16'h0001, 16'(v[4]));
		rd(`RBRM_A_WPP, v);
		chk("page kept", wp[7:0], v);
		$display("test overflow: done");
		// Halt with a remote count still set
		wr(`RBRM_A_RCL, 8'h01);
		wr(`RBRM_A_ISR, 8'hff);
		wr(`RBRM_A_CMD, `RBRM_CMD_RST);
		wait_stop(c);
		chk("idle halt", 16'h0001, 16'(c <= 3));
		rd(`RBRM_A_ISR, v);
		chk("flag waits", 16'h0000, 16'(v[7]));
		wr(`RBRM_A_RCL, 8'h00);
		wr(`RBRM_A_RCH, 8'h00);
		rd(`RBRM_A_ISR, v);
		chk("reset flag", 16'h0001, 16'(v[7]));
		// Halt under a busy transmitter, normal and loopback mode 1
		for (int m = 0; m < 2; m++)
		begin
			wr(`RBRM_A_CMD, 8'h22);
			wr(`RBRM_A_TCR, (m == 1) ? 8'h02 : 8'h00);
			wr(`RBRM_A_ISR, 8'hff);
			tx_busy <= 1'b1;
			wr(`RBRM_A_CMD, `RBRM_CMD_RST);
			wait_stop(c);
			c = c - ((m == 1) ? LB1_CYC : LONG_CYC);
			chk("forced halt", 16'h0001, 16'(c >= -4 && c <= 4));
			rd(`RBRM_A_ISR, v);
			chk("no flag", 16'h0000, 16'(v[7]));
			tx_busy <= 1'b0;
		end
		$display("test halt: done");
		// Started in loopback: nothing stored, then normal again
		wr(`RBRM_A_CMD, 8'h22);
		send(80, 3'b000, 0);
		chk("loopback writes", 16'h0000, 16'(wrote));
		remote(nxt(bnd_pg));
		wr(`RBRM_A_TCR, 8'h00);
		send(80, 3'b000, 1);
		$display("test loopback: done");
		summarize();
	end
endmodule // rbrm_top_test
